//--- rtl/status_flags_and_interrupt_ctrl.sv
// arithmetic status flags and three-source interrupt controller
`timescale 1ns/10ps
module status_flags_and_interrupt_ctrl #(
	parameter int ENDPOINTS = 3
) (
	input  wire logic                    clock,
	input  wire logic                    reset,
	input  wire logic                    clock_enable,
	input  wire logic                    second_clock_phase,
	input  wire logic [7:0]              reg_addr,
	input  wire logic                    reg_write,
	input  wire logic [7:0]              reg_wdata,
	output logic      [7:0]              reg_rdata,
	input  wire status_irq_pkg::alu_op_e alu_op,
	input  wire logic [7:0]              alu_a,
	input  wire logic [7:0]              alu_b,
	output logic      [7:0]              alu_result,
	output logic                         carry_flag,
	input  wire logic                    watchdog_timeout,
	input  wire logic                    watchdog_clear_instr,
	input  wire logic                    halt_instr,
	input  wire logic [ENDPOINTS-1:0]    endpoint_access,
	input  wire logic                    usb_suspend,
	input  wire logic                    usb_resume,
	input  wire logic                    usb_bus_reset,
	input  wire logic                    timer0_overflow,
	input  wire logic                    timer1_overflow,
	input  wire logic                    stack_full,
	input  wire logic                    interrupt_return_instr,
	input  wire logic                    plain_return_instr,
	output logic                         irq_call,
	output logic      [7:0]              irq_vector
);
	// ****************************************************************
	// parameter check
	// ****************************************************************
	if (ENDPOINTS < 1 || ENDPOINTS > 8)
	begin : bad_endpoints
		$error("endpoint count must be 1 to 8");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [3:0]           arith;
		logic                 power_down_flag;
		logic                 watchdog_timeout_flag;
		logic [3:0]           enables;
		logic [2:0]           requests;
		logic [ENDPOINTS-1:0] endpoint_request_register;
		logic                 suspend_line;
		logic                 resume_line;
		logic [7:0]           rdata;
		logic [7:0]           result;
		logic                 call;
		logic [7:0]           vector;
	} state_s;

	state_s               state;
	state_s               next_state;
	logic [7:0]           calc_result;
	logic [3:0]           calc_flags;
	logic [3:0]           calc_mask;
	logic [ENDPOINTS-1:0] next_endpoint;
	logic                 write_arith;
	logic                 write_irq;
	logic                 write_usb;
	logic                 write_endpoint;
	logic [2:0]           pending;
	logic [2:0]           set_requests;
	logic                 take;

	flag_calc alu_flags (
		.op        (alu_op),
		.a         (alu_a),
		.b         (alu_b),
		.carry_in  (state.arith[status_irq_pkg::CARRY_BIT]),
		.result    (calc_result),
		.flags     (calc_flags),
		.flag_mask (calc_mask)
	);

	assign write_arith    = reg_write && reg_addr == status_irq_pkg::ARITH_FLAG_ADDR;
	assign write_irq      = reg_write && reg_addr == status_irq_pkg::IRQ_CTRL_ADDR;
	assign write_usb      = reg_write && reg_addr == status_irq_pkg::USB_CTRL_ADDR;
	assign write_endpoint = reg_write && reg_addr == status_irq_pkg::EP_REQ_ADDR;

	// ****************************************************************
	// endpoint request bits
	// ****************************************************************
	// a write of zero clears, but an access in the same cycle keeps the bit
	for (genvar i = 0; i < ENDPOINTS; i++)
	begin : endpoint_bits
		assign next_endpoint[i] = (write_endpoint ? reg_wdata[i] : state.endpoint_request_register[i])
			| endpoint_access[i];
	end

	// bit order of requests: 0 usb, 1 timer 0, 2 timer 1
	assign set_requests = {timer1_overflow, timer0_overflow,
		(|endpoint_access) | usb_suspend | usb_resume | usb_bus_reset};
	assign pending      = state.requests & state.enables[3:1];
	// only latched requests are seen, so an event lands at the following phase edge
	assign take         = second_clock_phase && state.enables[status_irq_pkg::GLOBAL_EN_BIT]
		&& !stack_full && (|pending);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		next_state      = state;
		next_state.call = 1'b0;

		// alu results first; an explicit write to the register overrides them
		if (calc_mask != 4'h0)
		begin
			next_state.result = calc_result;
			next_state.arith  = (state.arith & ~calc_mask) | (calc_flags & calc_mask);
		end
		if (write_arith)
		begin
			next_state.arith = reg_wdata[3:0];
		end

		if (watchdog_clear_instr || halt_instr)
		begin
			next_state.watchdog_timeout_flag = 1'b0;
		end
		if (watchdog_timeout)
		begin
			next_state.watchdog_timeout_flag = 1'b1;
		end
		if (watchdog_clear_instr)
		begin
			next_state.power_down_flag = 1'b0;
		end
		if (halt_instr)
		begin
			next_state.power_down_flag = 1'b1;
		end

		if (write_irq)
		begin
			next_state.enables  = reg_wdata[3:0];
			next_state.requests = reg_wdata[6:4];
		end
		if (interrupt_return_instr)
		begin
			next_state.enables[status_irq_pkg::GLOBAL_EN_BIT] = 1'b1;
		end

		// only the program counter goes on the stack; the core does the push
		if (take)
		begin
			next_state.call                                   = 1'b1;
			next_state.enables[status_irq_pkg::GLOBAL_EN_BIT] = 1'b0;
			if (pending[0])
			begin
				next_state.vector      = status_irq_pkg::USB_VECTOR;
				next_state.requests[0] = 1'b0;
			end
			else if (pending[1])
			begin
				next_state.vector      = status_irq_pkg::TIMER0_VECTOR;
				next_state.requests[1] = 1'b0;
			end
			else
			begin
				next_state.vector      = status_irq_pkg::TIMER1_VECTOR;
				next_state.requests[2] = 1'b0;
			end
		end
		// requests are sticky whatever the enables say
		next_state.requests = next_state.requests | set_requests;

		next_state.endpoint_request_register = next_endpoint;
		next_state.suspend_line = (write_usb ? reg_wdata[status_irq_pkg::SUSPEND_BIT] : state.suspend_line)
			| usb_suspend;
		next_state.resume_line  = (write_usb ? reg_wdata[status_irq_pkg::RESUME_BIT] : state.resume_line)
			| usb_resume;

		case (reg_addr)
			status_irq_pkg::ARITH_FLAG_ADDR: next_state.rdata = {2'b00, state.watchdog_timeout_flag,
				state.power_down_flag, state.arith};
			status_irq_pkg::IRQ_CTRL_ADDR:   next_state.rdata = {1'b0, state.requests, state.enables};
			status_irq_pkg::USB_CTRL_ADDR:   next_state.rdata = {4'h0, state.resume_line, 2'b00, state.suspend_line};
			status_irq_pkg::EP_REQ_ADDR:     next_state.rdata = 8'(state.endpoint_request_register);
			default:                         next_state.rdata = 8'h00;
		endcase
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	// power-up is the reset: both watchdog flags clear
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state          <= '0;
			state.arith    <= status_irq_pkg::ARITH_RESET;
			state.enables  <= status_irq_pkg::ENABLE_RESET;
			state.requests <= status_irq_pkg::REQUEST_RESET;
		end
		else if (clock_enable)
		begin
			state <= next_state;
		end
	end

	assign reg_rdata  = state.rdata;
	assign alu_result = state.result;
	assign carry_flag = state.arith[status_irq_pkg::CARRY_BIT];
	assign irq_call   = state.call;
	assign irq_vector = state.vector;

	// ****************************************************************
	// checks
	// ****************************************************************
	unused_bits_zero_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && reg_addr == status_irq_pkg::ARITH_FLAG_ADDR |=> reg_rdata[7:6] == 2'b00)
		else $error("flag register upper bits not zero");

	write_keeps_watchdog_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && write_arith && !watchdog_clear_instr && !halt_instr && !watchdog_timeout
		|=> $stable(state.power_down_flag) && $stable(state.watchdog_timeout_flag))
		else $error("software write changed a watchdog flag");

	timeout_sets_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && watchdog_timeout |=> state.watchdog_timeout_flag)
		else $error("timeout did not set its flag");

	halt_flags_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && halt_instr && !watchdog_timeout
		|=> state.power_down_flag && !state.watchdog_timeout_flag)
		else $error("halt left the wrong watchdog flags");

	call_clears_global_a: assert property (
		@(posedge clock) disable iff (reset)
		irq_call |-> !state.enables[status_irq_pkg::GLOBAL_EN_BIT])
		else $error("global enable still set after a call");

	stack_full_blocks_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && stack_full |=> !irq_call)
		else $error("call taken while the stack was full");

	interrupt_return_instr_enables_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && interrupt_return_instr && !take
		|=> state.enables[status_irq_pkg::GLOBAL_EN_BIT])
		else $error("interrupt return did not set global enable");

	call_on_phase_a: assert property (
		@(posedge clock) disable iff (reset)
		irq_call && $past(clock_enable) |-> $past(second_clock_phase))
		else $error("call away from a second phase edge");

	priority_order_a: assert property (
		@(posedge clock) disable iff (reset)
		irq_call && $past(clock_enable) && irq_vector != status_irq_pkg::USB_VECTOR |-> !$past(pending[0]))
		else $error("lower priority served over pending usb");

	request_sticky_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && state.requests[1] && !take && !write_irq |=> state.requests[1])
		else $error("timer 0 request dropped without service");

	set_beats_clear_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && timer1_overflow |=> state.requests[2])
		else $error("timer 1 event lost");

	usb_vector_a: assert property (
		@(posedge clock) disable iff (reset)
		clock_enable && take && pending[0] |=> irq_call && irq_vector == status_irq_pkg::USB_VECTOR)
		else $error("usb service did not call 04h");
endmodule

//--- rtl/status_irq_pkg.sv
// constants and types shared by the status flag and interrupt control block
package status_irq_pkg;

	// ****************************************************************
	// register addresses in data memory
	// ****************************************************************
	localparam logic [7:0] ARITH_FLAG_ADDR   = 8'h0a;
	localparam logic [7:0] IRQ_CTRL_ADDR     = 8'h0b;
	localparam logic [7:0] USB_CTRL_ADDR     = 8'h1a;
	localparam logic [7:0] EP_REQ_ADDR       = 8'h1b;

	// ****************************************************************
	// arithmetic flag register fields
	// ****************************************************************
	localparam int CARRY_BIT      = 0;
	localparam int HALF_CARRY_BIT = 1;
	localparam int ZERO_BIT       = 2;
	localparam int OVERFLOW_BIT   = 3;
	localparam int POWER_DOWN_BIT = 4;
	localparam int TIMEOUT_BIT    = 5;

	// ****************************************************************
	// interrupt enable and request register fields
	// ****************************************************************
	localparam int GLOBAL_EN_BIT  = 0;
	localparam int USB_EN_BIT     = 1;
	localparam int TIMER0_EN_BIT  = 2;
	localparam int TIMER1_EN_BIT  = 3;
	localparam int USB_REQ_BIT    = 4;
	localparam int TIMER0_REQ_BIT = 5;
	localparam int TIMER1_REQ_BIT = 6;

	// ****************************************************************
	// usb control register fields
	// ****************************************************************
	localparam int SUSPEND_BIT = 0;
	localparam int RESUME_BIT  = 3;

	// ****************************************************************
	// vectors, in priority order usb, timer 0, timer 1
	// ****************************************************************
	localparam logic [7:0] USB_VECTOR    = 8'h04;
	localparam logic [7:0] TIMER0_VECTOR = 8'h08;
	localparam logic [7:0] TIMER1_VECTOR = 8'h0c;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [3:0] ARITH_RESET   = 4'h0;
	localparam logic [3:0] ENABLE_RESET  = 4'h0;
	localparam logic [2:0] REQUEST_RESET = 3'h0;

	// ****************************************************************
	// alu operations; all but op_none touch the flags
	// ****************************************************************
	typedef enum logic [3:0] {
		op_none,
		op_add,
		op_adc,
		op_sub,
		op_sbc,
		op_and,
		op_or,
		op_xor,
		op_rlc,
		op_rrc
	} alu_op_e;

endpackage

//--- rtl/flag_calc.sv
// combinational alu result and flag generation
`timescale 1ns/10ps
module flag_calc (
	input  wire status_irq_pkg::alu_op_e op,
	input  wire logic [7:0]              a,
	input  wire logic [7:0]              b,
	input  wire logic                    carry_in,
	output logic      [7:0]              result,
	output logic      [3:0]              flags,
	output logic      [3:0]              flag_mask
);
	logic       [7:0] operand;
	logic             cin;
	logic       [8:0] sum;
	logic       [4:0] low_sum;
	logic       [7:0] low7_sum;
	logic             arith;

	always_comb
	begin
		arith     = 1'b0;
		operand   = b;
		cin       = 1'b0;
		result    = 8'h00;
		flags     = 4'h0;
		flag_mask = 4'h0;
		case (op)
			status_irq_pkg::op_add: arith = 1'b1;
			status_irq_pkg::op_adc:
			begin
				arith = 1'b1;
				cin   = carry_in;
			end
			// subtraction adds the complement, so carry out means no borrow
			status_irq_pkg::op_sub:
			begin
				arith   = 1'b1;
				operand = ~b;
				cin     = 1'b1;
			end
			status_irq_pkg::op_sbc:
			begin
				arith   = 1'b1;
				operand = ~b;
				cin     = carry_in;
			end
			default: arith = 1'b0;
		endcase
		sum      = {1'b0, a} + {1'b0, operand} + {8'h00, cin};
		low_sum  = {1'b0, a[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
		low7_sum = {1'b0, a[6:0]} + {1'b0, operand[6:0]} + {7'h00, cin};
		if (arith)
		begin
			result                                   = sum[7:0];
			flags[status_irq_pkg::CARRY_BIT]         = sum[8];
			flags[status_irq_pkg::HALF_CARRY_BIT]    = low_sum[4];
			flags[status_irq_pkg::OVERFLOW_BIT]      = low7_sum[7] ^ sum[8];
			flags[status_irq_pkg::ZERO_BIT]          = (sum[7:0] == 8'h00);
			flag_mask                                = 4'hf;
		end
		else
		begin
			case (op)
				status_irq_pkg::op_and: result = a & b;
				status_irq_pkg::op_or:  result = a | b;
				status_irq_pkg::op_xor: result = a ^ b;
				status_irq_pkg::op_rlc: result = {a[6:0], carry_in};
				status_irq_pkg::op_rrc: result = {carry_in, a[7:1]};
				default:                result = 8'h00;
			endcase
			if (op == status_irq_pkg::op_rlc || op == status_irq_pkg::op_rrc)
			begin
				flags[status_irq_pkg::CARRY_BIT]     = (op == status_irq_pkg::op_rlc) ? a[7] : a[0];
				flag_mask[status_irq_pkg::CARRY_BIT] = 1'b1;
			end
			else if (op != status_irq_pkg::op_none)
			begin
				flags[status_irq_pkg::ZERO_BIT]      = (result == 8'h00);
				flag_mask[status_irq_pkg::ZERO_BIT]  = 1'b1;
			end
		end
	end
endmodule

//--- test/core_stack_model.sv
// core sequencer and return stack model facing the interrupt controller
`timescale 1ns/10ps
module core_stack_model (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       irq_call,
	input  wire logic [7:0] irq_vector,
	input  wire logic       push_req,
	input  wire logic       ret_req,
	input  wire logic       ret_is_irq,
	output logic            second_clock_phase,
	output logic            stack_full,
	output logic            interrupt_return_instr,
	output logic            plain_return_instr,
	output logic      [7:0] last_vector
);
	logic [1:0] phase;
	logic [3:0] depth;

	// one phase pulse per four-clock instruction cycle
	assign second_clock_phase = (phase == 2'h3);
	assign stack_full = (depth == 4'h8);

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			phase <= 2'h0;
			depth <= 4'h0;
			interrupt_return_instr <= 1'b0;
			plain_return_instr <= 1'b0;
			last_vector <= 8'h00;
		end
		else
		begin
			phase <= phase + 2'h1;
			interrupt_return_instr <= ret_req & ret_is_irq;
			plain_return_instr <= ret_req & ~ret_is_irq;
			// only the return address is pushed; flags are firmware's business
			if (irq_call)
			begin
				depth <= (depth == 4'h8) ? depth : depth + 4'h1;
				last_vector <= irq_vector;
			end
			else if (push_req && depth != 4'h8)
				depth <= depth + 4'h1;
			// pop on either return kind, so a full stack frees a level
			else if (ret_req && depth != 4'h0)
				depth <= depth - 4'h1;
		end
	end
endmodule

//--- test/status_flags_and_interrupt_ctrl_tb.sv
// self-checking bench for the status flag and interrupt control block
`timescale 1ns/10ps
`define check_eq(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("BAD %0t got %h expected %h", $time, (got), (exp)); \
		end \
	end

module status_flags_and_interrupt_ctrl_tb;
	logic                    clock = 1'b0;
	logic                    reset = 1'b1;
	logic                    clock_en = 1'b1;
	logic [7:0]              reg_addr = 8'h00;
	logic                    reg_write = 1'b0;
	logic [7:0]              reg_wdata = 8'h00;
	logic [7:0]              reg_rdata;
	status_irq_pkg::alu_op_e alu_op = status_irq_pkg::op_none;
	logic [7:0]              alu_a = 8'h00;
	logic [7:0]              alu_b = 8'h00;
	logic [7:0]              alu_result;
	logic                    carry_flag;
	logic [10:0]             ev = 11'h000;
	logic                    push_req = 1'b0;
	logic                    ret_req = 1'b0;
	logic                    ret_is_irq = 1'b0;
	logic                    phase_pulse;
	logic                    stack_full;
	logic                    irq_ret;
	logic                    plain_ret;
	logic                    irq_call;
	logic [7:0]              irq_vector;
	logic [7:0]              last_vector;
	int                      fail_count = 0;
	int                      total_checks = 0;
	logic [10:0]             wd_ev [5] = '{11'h004, 11'h001, 11'h004, 11'h002, 11'h001};
	logic [7:0]              wd_exp [5] = '{8'h10, 8'h30, 8'h10, 8'h00, 8'h20};
	logic [10:0]             usb_ev [6] = '{11'h008, 11'h010, 11'h020, 11'h100, 11'h200, 11'h400};

	always #20 clock = ~clock;

	status_flags_and_interrupt_ctrl i_dut (
		.clock(clock), .reset(reset), .clock_enable(clock_en), .second_clock_phase(phase_pulse),
		.reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_result(alu_result), .carry_flag(carry_flag),
		.watchdog_timeout(ev[0]), .watchdog_clear_instr(ev[1]), .halt_instr(ev[2]),
		.endpoint_access(ev[10:8]), .usb_suspend(ev[3]), .usb_resume(ev[4]), .usb_bus_reset(ev[5]),
		.timer0_overflow(ev[6]), .timer1_overflow(ev[7]), .stack_full(stack_full),
		.interrupt_return_instr(irq_ret), .plain_return_instr(plain_ret),
		.irq_call(irq_call), .irq_vector(irq_vector)
	);

	core_stack_model i_core (
		.clock(clock), .reset(reset), .irq_call(irq_call), .irq_vector(irq_vector),
		.push_req(push_req), .ret_req(ret_req), .ret_is_irq(ret_is_irq),
		.second_clock_phase(phase_pulse), .stack_full(stack_full),
		.interrupt_return_instr(irq_ret), .plain_return_instr(plain_ret), .last_vector(last_vector)
	);

	// ****************************************************************
	// access tasks
	// ****************************************************************
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_write <= 1'b1;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		@(posedge clock);
		#1;
		`check_eq(reg_rdata, exp)
	endtask

	task automatic fire(input logic [10:0] m);
		@(posedge clock);
		ev <= m;
		@(posedge clock);
		ev <= 11'h000;
	endtask

	task automatic core_op(input logic push, input logic ret, input logic kind);
		@(posedge clock);
		push_req <= push;
		ret_req <= ret;
		ret_is_irq <= kind;
		@(posedge clock);
		push_req <= 1'b0;
		ret_req <= 1'b0;
	endtask

	task automatic alu(input status_irq_pkg::alu_op_e op, input logic [7:0] a, b, res, flags);
		@(posedge clock);
		alu_op <= op;
		alu_a <= a;
		alu_b <= b;
		@(posedge clock);
		alu_op <= status_irq_pkg::op_none;
		#1;
		`check_eq(alu_result, res)
		`check_eq(carry_flag, flags[0])
		rd(status_irq_pkg::ARITH_FLAG_ADDR, flags);
	endtask

	task automatic no_call(input int n);
		repeat (n)
		begin
			@(posedge clock);
			#1;
			`check_eq(irq_call, 1'b0)
		end
	endtask

	// the call is a single-cycle pulse, so it is polled every cycle
	task automatic wait_call(input logic [7:0] vec);
		for (int n = 0; n < 30 && irq_call !== 1'b1; n++)
		begin
			@(posedge clock);
			#1;
		end
		if (irq_call !== 1'b1)
		begin
			fail_count++;
			$display("BAD %0t no interrupt call", $time);
			close_out();
		end
		else
		begin
			`check_eq(irq_vector, vec)
			no_call(1);
			// the core takes the vector on the edge after the call pulse
			`check_eq(last_vector, vec)
		end
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		rd(status_irq_pkg::ARITH_FLAG_ADDR, 8'h00);
		rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h00);
		rd(status_irq_pkg::USB_CTRL_ADDR, 8'h00);
		rd(status_irq_pkg::EP_REQ_ADDR, 8'h00);
		rd(8'h0c, 8'h00);
		wr(status_irq_pkg::ARITH_FLAG_ADDR, 8'hff);
		rd(status_irq_pkg::ARITH_FLAG_ADDR, 8'h0f);
		wr(status_irq_pkg::IRQ_CTRL_ADDR, 8'h8e);
		rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h0e);
		wr(status_irq_pkg::ARITH_FLAG_ADDR, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			fire(wd_ev[i]);
			rd(status_irq_pkg::ARITH_FLAG_ADDR, wd_exp[i]);
		end
		wr(status_irq_pkg::ARITH_FLAG_ADDR, 8'h0f);
		rd(status_irq_pkg::ARITH_FLAG_ADDR, 8'h2f);
		fire(11'h002);
		wr(status_irq_pkg::ARITH_FLAG_ADDR, 8'h00);
		alu(status_irq_pkg::op_add, 8'hff, 8'h01, 8'h00, 8'h07);
		alu(status_irq_pkg::op_add, 8'h7f, 8'h01, 8'h80, 8'h0a);
		alu(status_irq_pkg::op_sub, 8'h05, 8'h03, 8'h02, 8'h03);
		alu(status_irq_pkg::op_sub, 8'h03, 8'h05, 8'hfe, 8'h00);
		alu(status_irq_pkg::op_and, 8'h0f, 8'hf0, 8'h00, 8'h04);
		alu(status_irq_pkg::op_rlc, 8'h80, 8'h00, 8'h00, 8'h05);
		alu(status_irq_pkg::op_adc, 8'h01, 8'h01, 8'h03, 8'h00);
		alu(status_irq_pkg::op_sbc, 8'h05, 8'h03, 8'h01, 8'h03);
		alu(status_irq_pkg::op_or, 8'h00, 8'h00, 8'h00, 8'h07);
		alu(status_irq_pkg::op_xor, 8'h5a, 8'h5a, 8'h00, 8'h07);
		alu(status_irq_pkg::op_rrc, 8'h02, 8'h00, 8'h81, 8'h06);
		for (int i = 0; i < 6; i++)
		begin
			wr(status_irq_pkg::IRQ_CTRL_ADDR, 8'h00);
			fire(usb_ev[i]);
			rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h10);
		end
		rd(status_irq_pkg::USB_CTRL_ADDR, 8'h09);
		rd(status_irq_pkg::EP_REQ_ADDR, 8'h07);
		wr(status_irq_pkg::EP_REQ_ADDR, 8'h00);
		rd(status_irq_pkg::EP_REQ_ADDR, 8'h00);
		wr(status_irq_pkg::IRQ_CTRL_ADDR, 8'h0e);
		fire(11'h0e0);
		no_call(10);
		rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h7e);
		wr(status_irq_pkg::IRQ_CTRL_ADDR, 8'h7f);
		wait_call(status_irq_pkg::USB_VECTOR);
		rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h6e);
		core_op(1'b0, 1'b1, 1'b0);
		no_call(10);
		core_op(1'b0, 1'b1, 1'b1);
		wait_call(status_irq_pkg::TIMER0_VECTOR);
		core_op(1'b0, 1'b1, 1'b1);
		wait_call(status_irq_pkg::TIMER1_VECTOR);
		rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h0e);
		repeat (8) core_op(1'b1, 1'b0, 1'b0);
		wr(status_irq_pkg::IRQ_CTRL_ADDR, 8'h05);
		fire(11'h040);
		no_call(12);
		core_op(1'b0, 1'b1, 1'b0);
		wait_call(status_irq_pkg::TIMER0_VECTOR);
		rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h04);
		// software clear and timer event land on the same edge
		@(posedge clock);
		reg_addr <= status_irq_pkg::IRQ_CTRL_ADDR;
		reg_write <= 1'b1;
		reg_wdata <= 8'h00;
		ev <= 11'h080;
		@(posedge clock);
		reg_write <= 1'b0;
		ev <= 11'h000;
		rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h40);
		// frozen block ignores a halt pulse
		@(posedge clock);
		clock_en <= 1'b0;
		fire(11'h004);
		@(posedge clock);
		clock_en <= 1'b1;
		rd(status_irq_pkg::ARITH_FLAG_ADDR, 8'h06);
		rd(status_irq_pkg::IRQ_CTRL_ADDR, 8'h40);
		close_out();
	end
endmodule
